// >>> slce_engine.sv
// Overview of operation
// - Remote access guard disabled after reset.
// - Programmable reply timeout fails waiting commands.
// - Stream transmit payload 128/256, byte count.
// - Stream receive payload, destination size, count.
// - Control trigger flag held until sent.
// - Status bits cleared via separate clear registers.
// - Control payload zero with trigger sends ping.
// - Valid received key sets authentication flag.
// - Transport commands need completed authentication first.
// - Four channels; windows four and above invalid.
// - Ready flag set once read sent.
// - Data-valid flag marks returned read data.
// - Reference clock 10/20 MHz, role select.
// - Standby bit holds link; clearing activates.
module slce_engine (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic link_clk_in,
	input wire logic link_rxd_in,
	output logic link_txd_out,
	output logic reference_clock_pin_out,
	output logic reference_clock_pin_oe_out
);

	slce_pkg::slce_state_t s;
	slce_pkg::slce_state_t next_s;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
				r[b*8 +: 8] = wd[b*8 +: 8];
		end
		return r;
	endfunction

	always_comb
	begin
		logic [7:0] wa;
		logic [7:0] ra;
		logic [7:0] co;
		logic [1:0] ci;
		logic [31:0] wv;
		logic [31:0] rv;
		logic [1:0] rr;
		logic rise;
		logic fall;
		logic done;
		logic found;
		logic [69:0] fr;
		logic [3:0] code;
		logic [1:0] chan;
		logic [31:0] arg0;
		logic [31:0] arg1;
		logic [31:0] txb;
		logic [31:0] rxb;
		logic [31:0] cnt;
		logic blocked;
		next_s = s;
		wa = {s.aw_addr[7:2], 2'b00};
		ra = {s_axi_araddr_in[7:2], 2'b00};
		co = 8'h00;
		ci = 2'h0;
		wv = merge(32'h0000_0000, s.w_data, s.w_strb);
		rv = 32'h0000_0000;
		rr = slce_pkg::RESP_OKAY;
		done = 1'b0;
		found = 1'b0;
		fr = {s.rx_sh[68:0], s.rxd_s2};
		code = fr[69:66];
		chan = fr[65:64];
		arg0 = fr[63:32];
		arg1 = fr[31:0];
		txb = s.stx_size ? slce_pkg::PAY256_BYTES : slce_pkg::PAY128_BYTES;
		rxb = s.srx_size ? slce_pkg::PAY256_BYTES : slce_pkg::PAY128_BYTES;
		cnt = s.srx_cnt + rxb;
		blocked = ~s.unlocked | s.mode[slce_pkg::MODE_GUARD];

		// The second and third stages of the link clock synchroniser feed the edge detectors.
		next_s.lclk_s1 = link_clk_in;
		next_s.lclk_s2 = s.lclk_s1;
		next_s.lclk_s3 = s.lclk_s2;
		next_s.rxd_s1 = link_rxd_in;
		next_s.rxd_s2 = s.rxd_s1;
		rise = s.lclk_s2 & ~s.lclk_s3 & ~s.pll_stby;
		fall = ~s.lclk_s2 & s.lclk_s3 & ~s.pll_stby;

		// Register write: address and data may arrive in either order.
		if (s.awready && s_axi_awvalid_in)
		begin
			next_s.aw_got = 1'b1;
			next_s.aw_addr = s_axi_awaddr_in;
		end
		if (s.wready && s_axi_wvalid_in)
		begin
			next_s.w_got = 1'b1;
			next_s.w_data = s_axi_wdata_in;
			next_s.w_strb = s_axi_wstrb_in;
		end
		if (s.bvalid && s_axi_bready_in)
			next_s.bvalid = 1'b0;
		if (s.aw_got && s.w_got && !s.bvalid)
		begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = slce_pkg::RESP_OKAY;
			co = wa - slce_pkg::OFS_CH_BASE;
			ci = co[6:5];
			if (wa >= slce_pkg::OFS_CH_BASE && wa < slce_pkg::OFS_CH_END)
			begin
				unique case (co[4:0])
					slce_pkg::CH_ADDR: next_s.ch[ci].addr = merge(s.ch[ci].addr, s.w_data, s.w_strb);
					slce_pkg::CH_DATA: next_s.ch[ci].data = merge(s.ch[ci].data, s.w_data, s.w_strb);
					slce_pkg::CH_CLR: next_s.ch[ci].st = s.ch[ci].st & ~wv[6:0];
					slce_pkg::CH_CMD:
					begin
						if (s.ch[ci].phase != slce_pkg::SLCE_CH_IDLE)
							next_s.ch[ci].st[slce_pkg::CS_REJECT] = 1'b1;
						else if (wv[6:4] >= slce_pkg::WINDOW_LIMIT
							|| wv[2:0] == 3'h0 || wv[2:0] > slce_pkg::CMD_STREAM_RX
							|| (wv[2:0] >= slce_pkg::CMD_STREAM_TX && ci != slce_pkg::STREAM_CH)
							|| (!s.unlocked && !(wv[2:0] == slce_pkg::CMD_WRITE32
							&& s.ch[ci].addr == slce_pkg::AUTH_KEY_ADDR)))
							next_s.ch[ci].st[slce_pkg::CS_REJECT] = 1'b1;
						else
						begin
							next_s.ch[ci].cmd = wv[2:0];
							next_s.ch[ci].timer = 32'h0000_0000;
							next_s.ch[ci].offset = 32'h0000_0000;
							next_s.ch[ci].left = s.stx_bc;
							next_s.ch[ci].phase = slce_pkg::SLCE_CH_QUEUED;
							if (wv[2:0] == slce_pkg::CMD_STREAM_RX)
							begin
								next_s.ch[ci].phase = slce_pkg::SLCE_CH_WAIT;
								next_s.srx_armed = 1'b1;
								next_s.srx_cnt = 32'h0000_0000;
							end
						end
					end
					default: next_s.bresp = slce_pkg::RESP_SLVERR;
				endcase
			end
			else
			begin
				unique case (wa)
					slce_pkg::OFS_MODE: next_s.mode = wv[2:0] | (s.mode & ~{3{s.w_strb[0]}});
					slce_pkg::OFS_PLL: next_s.pll_stby = s.w_strb[0] ? wv[0] : s.pll_stby;
					slce_pkg::OFS_CTRL_CMD:
					begin
						// A trigger while one is still pending is dropped.
						if (!s.ctrl_trig && wv[slce_pkg::CTRL_TRIG])
						begin
							next_s.ctrl_payload = wv[7:0];
							if (wv[7:0] == slce_pkg::PING_PAYLOAD)
								next_s.ctrl_trig = 1'b1;
							else
								next_s.main_st[slce_pkg::MS_CTRL_ERR] = 1'b1;
						end
					end
					slce_pkg::OFS_MAIN_CLR: next_s.main_st = s.main_st & ~wv[6:0];
					slce_pkg::OFS_KEY: next_s.key = merge(s.key, s.w_data, s.w_strb);
					slce_pkg::OFS_TIMEOUT: next_s.timeout = merge(s.timeout, s.w_data, s.w_strb);
					slce_pkg::OFS_STX_MODE: next_s.stx_size = s.w_strb[0] ? wv[0] : s.stx_size;
					slce_pkg::OFS_STX_BC: next_s.stx_bc = merge(s.stx_bc, s.w_data, s.w_strb);
					slce_pkg::OFS_SRX_MODE: next_s.srx_size = s.w_strb[0] ? wv[0] : s.srx_size;
					slce_pkg::OFS_SRX_DS: next_s.srx_ds = merge(s.srx_ds, s.w_data, s.w_strb);
					slce_pkg::OFS_SRX_BC: next_s.srx_bc = merge(s.srx_bc, s.w_data, s.w_strb);
					slce_pkg::OFS_SRX_ADDR: next_s.srx_addr = merge(s.srx_addr, s.w_data, s.w_strb);
					slce_pkg::OFS_STX_SRC: next_s.stx_src = merge(s.stx_src, s.w_data, s.w_strb);
					default: next_s.bresp = slce_pkg::RESP_SLVERR;
				endcase
			end
		end
		next_s.awready = ~next_s.aw_got;
		next_s.wready = ~next_s.w_got;

		// Register read.
		co = ra - slce_pkg::OFS_CH_BASE;
		if (ra >= slce_pkg::OFS_CH_BASE && ra < slce_pkg::OFS_CH_END)
		begin
			unique case (co[4:0])
				slce_pkg::CH_ADDR: rv = s.ch[co[6:5]].addr;
				slce_pkg::CH_DATA: rv = s.ch[co[6:5]].data;
				slce_pkg::CH_CMD: rv = {29'h0000_0000, s.ch[co[6:5]].cmd};
				slce_pkg::CH_ST:
				begin
					rv = {25'h000_0000, s.ch[co[6:5]].st};
					rv[slce_pkg::CS_BUSY] = s.ch[co[6:5]].phase != slce_pkg::SLCE_CH_IDLE;
				end
				slce_pkg::CH_CLR: rv = 32'h0000_0000;
				default: rr = slce_pkg::RESP_SLVERR;
			endcase
		end
		else
		begin
			unique case (ra)
				slce_pkg::OFS_MODE: rv = {29'h0000_0000, s.mode};
				slce_pkg::OFS_PLL: rv = {31'h0000_0000, s.pll_stby};
				slce_pkg::OFS_CTRL_CMD: rv = {23'h00_0000, s.ctrl_trig, s.ctrl_payload};
				slce_pkg::OFS_MAIN_ST:
				begin
					rv = {25'h000_0000, s.main_st};
					rv[slce_pkg::MS_UNLOCK] = s.unlocked;
				end
				slce_pkg::OFS_MAIN_CLR: rv = 32'h0000_0000;
				slce_pkg::OFS_KEY: rv = s.key;
				slce_pkg::OFS_TIMEOUT: rv = s.timeout;
				slce_pkg::OFS_STX_MODE: rv = {31'h0000_0000, s.stx_size};
				slce_pkg::OFS_STX_BC: rv = s.stx_bc;
				slce_pkg::OFS_SRX_MODE: rv = {31'h0000_0000, s.srx_size};
				slce_pkg::OFS_SRX_DS: rv = s.srx_ds;
				slce_pkg::OFS_SRX_BC: rv = s.srx_bc;
				slce_pkg::OFS_SRX_ADDR: rv = s.srx_addr;
				slce_pkg::OFS_STX_SRC: rv = s.stx_src;
				slce_pkg::OFS_SRX_CNT: rv = s.srx_cnt;
				default: rr = slce_pkg::RESP_SLVERR;
			endcase
		end
		if (s.rvalid && s_axi_rready_in)
			next_s.rvalid = 1'b0;
		if (s.arready && s_axi_arvalid_in)
		begin
			next_s.rvalid = 1'b1;
			next_s.rdata = rv;
			next_s.rresp = rr;
		end
		next_s.arready = ~next_s.rvalid;

		// Reply timers; a stream receive waits on the partner's data instead.
		for (int i = 0; i < slce_pkg::NUM_CH; i++)
		begin
			if (s.ch[i].phase == slce_pkg::SLCE_CH_WAIT && s.ch[i].cmd != slce_pkg::CMD_STREAM_RX)
			begin
				next_s.ch[i].timer = s.ch[i].timer + slce_pkg::ONE32;
				if (s.timeout != 32'h0000_0000 && s.ch[i].timer >= s.timeout)
				begin
					next_s.ch[i].phase = slce_pkg::SLCE_CH_IDLE;
					next_s.ch[i].st[slce_pkg::CS_TIMEOUT] = 1'b1;
				end
			end
		end

		// Transmitter: start bit, then code, channel and two words, MSB first.
		if (fall)
		begin
			if (s.tx_busy && s.tx_cnt != 7'h00)
			begin
				next_s.txd = s.tx_sh[69];
				next_s.tx_sh = {s.tx_sh[68:0], 1'b0};
				next_s.tx_cnt = s.tx_cnt - slce_pkg::FRAME_LAST;
			end
			else if (s.tx_busy)
			begin
				next_s.txd = 1'b0;
				next_s.tx_busy = 1'b0;
			end
			else
			begin
				next_s.tx_cnt = slce_pkg::FRAME_BITS;
				if (s.resp_pend)
				begin
					found = 1'b1;
					next_s.resp_pend = 1'b0;
					next_s.tx_sh = {s.resp_code, s.resp_chan, s.resp_arg0, s.resp_arg1};
				end
				else if (s.ctrl_trig)
				begin
					found = 1'b1;
					next_s.ctrl_trig = 1'b0;
					next_s.tx_sh = {slce_pkg::F_PING, 2'h0, 32'h0000_0000, 32'h0000_0000};
				end
				for (int i = 0; i < slce_pkg::NUM_CH; i++)
				begin
					if (!found && s.ch[i].phase == slce_pkg::SLCE_CH_QUEUED)
					begin
						found = 1'b1;
						next_s.ch[i].phase = slce_pkg::SLCE_CH_WAIT;
						next_s.ch[i].timer = 32'h0000_0000;
						next_s.ch[i].st[slce_pkg::CS_RDY] = 1'b1;
						unique case (s.ch[i].cmd)
							slce_pkg::CMD_READ32:
								next_s.tx_sh = {slce_pkg::F_RD, 2'(i), s.ch[i].addr, 32'h0000_0000};
							slce_pkg::CMD_WRITE32:
								next_s.tx_sh = {slce_pkg::F_WR, 2'(i), s.ch[i].addr, s.ch[i].data};
							default:
								next_s.tx_sh = {slce_pkg::F_ST, 2'(i), s.ch[i].addr + s.ch[i].offset,
									s.stx_src + s.ch[i].offset};
						endcase
					end
				end
				next_s.tx_busy = found;
				next_s.txd = found;
			end
		end

		// Receiver.
		if (rise)
		begin
			if (!s.rx_busy)
			begin
				next_s.rx_busy = s.rxd_s2;
				next_s.rx_cnt = slce_pkg::FRAME_BITS;
			end
			else
			begin
				next_s.rx_sh = fr;
				next_s.rx_cnt = s.rx_cnt - slce_pkg::FRAME_LAST;
				if (s.rx_cnt == slce_pkg::FRAME_LAST)
				begin
					next_s.rx_busy = 1'b0;
					done = 1'b1;
				end
			end
		end
		if (done)
		begin
			next_s.resp_chan = chan;
			next_s.resp_arg0 = arg0;
			next_s.resp_arg1 = 32'h0000_0000;
			next_s.resp_code = slce_pkg::F_NACK;
			unique case (code)
				slce_pkg::F_PING:
				begin
					next_s.resp_pend = 1'b1;
					next_s.resp_code = slce_pkg::F_PING_ACK;
				end
				slce_pkg::F_PING_ACK: next_s.main_st[slce_pkg::MS_PING_OK] = 1'b1;
				slce_pkg::F_WR, slce_pkg::F_RD:
				begin
					next_s.resp_pend = 1'b1;
					if (code == slce_pkg::F_WR && arg0 == slce_pkg::AUTH_KEY_ADDR)
					begin
						if (arg1 == s.key)
						begin
							next_s.main_st[slce_pkg::MS_AUTH] = 1'b1;
							next_s.unlocked = 1'b1;
							next_s.resp_code = slce_pkg::F_WR_ACK;
						end
					end
					else if (blocked)
						next_s.main_st[slce_pkg::MS_REMOTE_REJ] = 1'b1;
					else if (code == slce_pkg::F_WR)
					begin
						next_s.mbox[chan] = arg1;
						next_s.resp_code = slce_pkg::F_WR_ACK;
					end
					else
					begin
						next_s.resp_arg1 = s.mbox[chan];
						next_s.resp_code = slce_pkg::F_RD_RESP;
					end
				end
				slce_pkg::F_ST:
				begin
					next_s.resp_pend = 1'b1;
					if (s.srx_armed && !blocked)
					begin
						if (cnt > s.srx_ds)
						begin
							next_s.main_st[slce_pkg::MS_RX_OVF] = 1'b1;
							next_s.srx_armed = 1'b0;
							next_s.ch[slce_pkg::STREAM_CH].phase = slce_pkg::SLCE_CH_IDLE;
							next_s.ch[slce_pkg::STREAM_CH].st[slce_pkg::CS_NACK] = 1'b1;
						end
						else
						begin
							next_s.srx_cnt = cnt;
							next_s.ch[slce_pkg::STREAM_CH].data = arg1;
							next_s.resp_code = slce_pkg::F_ST_ACK;
							if (cnt >= s.srx_bc)
							begin
								next_s.main_st[slce_pkg::MS_RX_DONE] = 1'b1;
								next_s.srx_armed = 1'b0;
								next_s.ch[slce_pkg::STREAM_CH].phase = slce_pkg::SLCE_CH_IDLE;
								next_s.ch[slce_pkg::STREAM_CH].st[slce_pkg::CS_DONE] = 1'b1;
							end
						end
					end
				end
				default:
				begin
					// Replies close the waiting command of the channel they name; a stream ack with bytes left queues the next chunk instead.
					if (s.ch[chan].phase == slce_pkg::SLCE_CH_WAIT
						&& s.ch[chan].cmd != slce_pkg::CMD_STREAM_RX)
					begin
						next_s.ch[chan].phase = slce_pkg::SLCE_CH_IDLE;
						next_s.ch[chan].st[slce_pkg::CS_DONE] = 1'b1;
						if (code == slce_pkg::F_RD_RESP)
						begin
							next_s.ch[chan].data = arg1;
							next_s.ch[chan].st[slce_pkg::CS_DVALID] = 1'b1;
						end
						else if (code == slce_pkg::F_WR_ACK && s.ch[chan].addr == slce_pkg::AUTH_KEY_ADDR)
							next_s.unlocked = 1'b1;
						else if (code == slce_pkg::F_ST_ACK && s.ch[chan].left > txb)
						begin
							next_s.ch[chan].left = s.ch[chan].left - txb;
							next_s.ch[chan].offset = s.ch[chan].offset + txb;
							next_s.ch[chan].phase = slce_pkg::SLCE_CH_QUEUED;
							next_s.ch[chan].st[slce_pkg::CS_DONE] = 1'b0;
						end
						else if (code != slce_pkg::F_WR_ACK && code != slce_pkg::F_ST_ACK)
						begin
							next_s.ch[chan].st[slce_pkg::CS_DONE] = 1'b0;
							next_s.ch[chan].st[slce_pkg::CS_NACK] = 1'b1;
						end
					end
				end
			endcase
		end

		// Reference clock is driven only by the master and never in standby.
		next_s.reference_clock_pin_oe = s.mode[slce_pkg::MODE_ROLE] & ~s.pll_stby;
		if (!next_s.reference_clock_pin_oe)
		begin
			next_s.reference_clock_pin = 1'b0;
			next_s.ref_div = 2'h0;
		end
		else if (s.ref_div >= (s.mode[slce_pkg::MODE_REFERENCE_CLOCK_PIN_FREQUENCY_SELECT] ? slce_pkg::HALF20 : slce_pkg::HALF10))
		begin
			next_s.ref_div = 2'h0;
			next_s.reference_clock_pin = ~s.reference_clock_pin;
		end
		else
			next_s.ref_div = s.ref_div + 2'h1;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!rstn_in)
		begin
			s <= '0;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
			s.pll_stby <= 1'b1;
			s.mode <= 3'h0;
			s.timeout <= slce_pkg::TIMEOUT_RST;
		end
		else
			s <= next_s;
	end

	assign s_axi_awready_out = s.awready;
	assign s_axi_wready_out = s.wready;
	assign s_axi_bresp_out = s.bresp;
	assign s_axi_bvalid_out = s.bvalid;
	assign s_axi_arready_out = s.arready;
	assign s_axi_rdata_out = s.rdata;
	assign s_axi_rresp_out = s.rresp;
	assign s_axi_rvalid_out = s.rvalid;
	assign link_txd_out = s.txd;
	assign reference_clock_pin_out = s.reference_clock_pin;
	assign reference_clock_pin_oe_out = s.reference_clock_pin_oe;

endmodule

// >>> slce_engine_props.sv
module slce_engine_props (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic [1:0] s_axi_bresp_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic link_txd_out
);
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rstn_in);
	AST_B_ANSWER: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
		&& s_axi_wready_out && !s_axi_bvalid_out |=> !s_axi_awready_out && !s_axi_wready_out
		##1 s_axi_bvalid_out && s_axi_awready_out) else $error("write answer late");
	AST_B_HOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out
		&& $stable(s_axi_bresp_out)) else $error("write response not held");
	AST_B_DROP: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
		else $error("write response not released");
	AST_R_ANSWER: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read answer late");
	AST_R_HOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out
		&& $stable(s_axi_rdata_out)) else $error("read data not held");
	AST_R_DROP: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out
		&& s_axi_arready_out) else $error("read data not released");
	AST_AR_BLOCK: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("read address taken while busy");
	// A link bit lasts eight cycles; six leaves room for the input synchroniser.
	AST_TXD_BIT: assert property ($changed(link_txd_out) |=> $stable(link_txd_out)[*6])
		else $error("link bit too short");
	cover property (s_axi_bvalid_out && s_axi_bresp_out == 2'h2);
	cover property ($rose(link_txd_out));
	cover property (s_axi_rvalid_out && s_axi_rready_in);
endmodule

bind slce_engine slce_engine_props u_props (.*);

// >>> slce_engine_tb_top.sv
module slce_engine_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] RW = 32'h5A5A_0001;
	logic clk, rstn, awv, wv, bry, arv, rry, mute, awr, wr, bv, arr, rv, lclk, lrxd, ltxd;
	logic pgo, roe;
	logic [69:0] pf;
	logic [7:0] awa, ara;
	logic [31:0] wd, rdt, d;
	logic [1:0] br, rr;
	int err_total, n_tests;
	slce_engine dut (
		.ref_clk_in(clk),
		.rstn_in(rstn),
		.s_axi_awaddr_in(awa),
		.s_axi_awvalid_in(awv),
		.s_axi_awready_out(awr),
		.s_axi_wdata_in(wd),
		.s_axi_wstrb_in(4'hF),
		.s_axi_wvalid_in(wv),
		.s_axi_wready_out(wr),
		.s_axi_bresp_out(br),
		.s_axi_bvalid_out(bv),
		.s_axi_bready_in(bry),
		.s_axi_araddr_in(ara),
		.s_axi_arvalid_in(arv),
		.s_axi_arready_out(arr),
		.s_axi_rdata_out(rdt),
		.s_axi_rresp_out(rr),
		.s_axi_rvalid_out(rv),
		.s_axi_rready_in(rry),
		.link_clk_in(lclk),
		.link_rxd_in(lrxd),
		.link_txd_out(ltxd),
		.reference_clock_pin_out(),
		.reference_clock_pin_oe_out(roe)
	);
	slce_peer #(.READ_WORD(RW)) peer (.link_txd_in(ltxd), .mute_in(mute), .req_go_in(pgo),
		.req_in(pf), .link_clk_out(lclk), .link_rxd_out(lrxd));
	// The peer samples the request between two falling link edges, so it is sent once.
	task automatic inj(input logic [69:0] f);
		pf <= f;
		@(negedge lclk);
		pgo <= 1'b1;
		@(negedge lclk);
		pgo <= 1'b0;
	endtask
	task automatic tally_and_finish();
		if (err_total == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			err_total++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e = 2'h0);
		awa <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awr)
				awv <= 1'b0;
			if (wr)
				wv <= 1'b0;
		end while ((awv && !awr) || (wv && !wr));
		do @(posedge clk); while (bv !== 1'b1);
		chk(32'(br), 32'(e));
		bry <= 1'b1;
		@(posedge clk);
		bry <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a);
		ara <= a;
		arv <= 1'b1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge clk); while (rv !== 1'b1);
		d = rdt;
		chk(32'(rr), 32'h0000_0000);
		rry <= 1'b1;
		@(posedge clk);
		rry <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		axr(a);
		chk(d, e);
	endtask
	task automatic rbit(input logic [7:0] a, input int b, input logic [31:0] e);
		axr(a);
		chk(32'(d[b]), e);
	endtask
	task automatic wbit(input logic [7:0] a, input int b);
		do axr(a); while (d[b] !== 1'b1);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial
	begin
		#2000000;
		err_total++;
		tally_and_finish();
	end
	initial
	begin
		{rstn, awv, wv, bry, arv, rry, mute, pgo, pf, awa, ara, wd, err_total, n_tests} = '0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rchk(8'h00, 32'h0000_0000);
		rchk(8'h04, 32'h0000_0001);
		rchk(8'h18, 32'h0000_0400);
		axw(8'h18, 32'h0000_1000);
		axw(8'hFC, 32'h0000_0001, 2'h2);
		axw(8'h00, 32'h0000_0003);
		rchk(8'h00, 32'h0000_0003);
		chk(32'(roe), 32'h0000_0000);
		axw(8'h04, 32'h0000_0000);
		chk(32'(roe), 32'h0000_0001);
		axw(8'h08, 32'h0000_0100);
		wbit(8'h0C, 2);
		rbit(8'h08, 8, 32'h0000_0000);
		axw(8'h08, 32'h0000_0155);
		rbit(8'h0C, 3, 32'h0000_0001);
		axw(8'h10, 32'h0000_0008);
		rbit(8'h0C, 3, 32'h0000_0000);
		axw(8'h60, 32'h0000_0010);
		axw(8'h68, 32'h0000_0001);
		rbit(8'h6C, 4, 32'h0000_0001);
		axw(8'h40, 32'hFFFF_FF00);
		axw(8'h44, 32'h1234_ABCD);
		axw(8'h48, 32'h0000_0002);
		wbit(8'h0C, 1);
		axw(8'h70, 32'h0000_007F);
		axw(8'h68, 32'h0000_0041);
		rbit(8'h6C, 4, 32'h0000_0001);
		axw(8'h70, 32'h0000_007F);
		axw(8'h68, 32'h0000_0001);
		axw(8'h68, 32'h0000_0001);
		wbit(8'h6C, 5);
		rchk(8'h64, RW);
		rchk(8'h6C, 32'h0000_0035);
		axw(8'h50, 32'h0000_007F);
		axw(8'h48, 32'h0000_0003);
		rbit(8'h4C, 4, 32'h0000_0001);
		axw(8'h1C, 32'h0000_0000);
		axw(8'h20, 32'h0000_0020);
		axw(8'h34, 32'h0000_1000);
		axw(8'h90, 32'h0000_007F);
		axw(8'h80, 32'h0000_2000);
		axw(8'h88, 32'h0000_0003);
		wbit(8'h8C, 5);
		rchk(8'h8C, 32'h0000_0021);
		axw(8'h14, 32'h1234_ABCD);
		inj({4'h3, 2'h0, 32'hFFFF_FF00, 32'h1234_ABCD});
		wbit(8'h0C, 0);
		axw(8'h24, 32'h0000_0000);
		axw(8'h28, 32'h0000_0020);
		axw(8'h2C, 32'h0000_0010);
		axw(8'h30, 32'h0000_3000);
		axw(8'h88, 32'h0000_0004);
		inj({4'h7, 2'h2, 32'h0000_3000, 32'hCAFE_0001});
		wbit(8'h0C, 4);
		rchk(8'h84, 32'hCAFE_0001);
		rchk(8'h38, 32'h0000_0010);
		axw(8'h00, 32'h0000_0007);
		inj({4'h3, 2'h1, 32'h0000_0010, 32'h0000_0001});
		wbit(8'h0C, 6);
		axw(8'h18, 32'h0000_0040);
		mute <= 1'b1;
		axw(8'h70, 32'h0000_007F);
		axw(8'h68, 32'h0000_0001);
		wbit(8'h6C, 3);
		rbit(8'h6C, 1, 32'h0000_0000);
		tally_and_finish();
	end
endmodule

// >>> slce_peer.sv
module slce_peer #(
	parameter logic [31:0] READ_WORD = 32'h5A5A_0001
) (
	input wire logic link_txd_in,
	input wire logic mute_in,
	input wire logic req_go_in,
	input wire logic [69:0] req_in,
	output logic link_clk_out,
	output logic link_rxd_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [68:0] rx;
	logic [71:0] tx;
	logic [69:0] f;
	int n;
	initial
	begin
		rx = '0;
		tx = '0;
		n = 0;
		link_rxd_out = 1'b0;
		link_clk_out = 1'b0;
		forever #100 link_clk_out = ~link_clk_out;
	end
	assign f = {rx, link_txd_in};
	// Unless muted, every request gets its code plus one; a read carries the fixed word back.
	// Replies (even codes) and nacks are never answered, so no echo loop starts.
	always @(posedge link_clk_out)
	begin
		if (req_go_in)
			tx <= {1'b1, req_in, 1'b0};
		if (n == 0 && link_txd_in)
			n <= 70;
		else if (n > 0)
		begin
			rx <= f[68:0];
			n <= n - 1;
			if (n == 1 && !mute_in && f[66] && f[69:66] != 4'h9)
				tx <= {1'b1, f[69:66] + 4'h1, f[65:32], f[69:66] == 4'h5 ? READ_WORD : f[31:0], 1'b0};
		end
	end
	always @(negedge link_clk_out)
	begin
		link_rxd_out <= tx[71];
		tx <= {tx[70:0], 1'b0};
	end
endmodule

// >>> slce_pkg.sv
package slce_pkg;

	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int NUM_CH = 4;

	// Register byte offsets.
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_PLL = 8'h04;
	localparam logic [7:0] OFS_CTRL_CMD = 8'h08;
	localparam logic [7:0] OFS_MAIN_ST = 8'h0C;
	localparam logic [7:0] OFS_MAIN_CLR = 8'h10;
	localparam logic [7:0] OFS_KEY = 8'h14;
	localparam logic [7:0] OFS_TIMEOUT = 8'h18;
	localparam logic [7:0] OFS_STX_MODE = 8'h1C;
	localparam logic [7:0] OFS_STX_BC = 8'h20;
	localparam logic [7:0] OFS_SRX_MODE = 8'h24;
	localparam logic [7:0] OFS_SRX_DS = 8'h28;
	localparam logic [7:0] OFS_SRX_BC = 8'h2C;
	localparam logic [7:0] OFS_SRX_ADDR = 8'h30;
	localparam logic [7:0] OFS_STX_SRC = 8'h34;
	localparam logic [7:0] OFS_SRX_CNT = 8'h38;
	localparam logic [7:0] OFS_CH_BASE = 8'h40;
	localparam logic [7:0] OFS_CH_END = 8'hC0;
	localparam logic [4:0] CH_ADDR = 5'h00;
	localparam logic [4:0] CH_DATA = 5'h04;
	localparam logic [4:0] CH_CMD = 5'h08;
	localparam logic [4:0] CH_ST = 5'h0C;
	localparam logic [4:0] CH_CLR = 5'h10;

	// Field positions.
	localparam int MODE_ROLE = 0;
	localparam int MODE_REFERENCE_CLOCK_PIN_FREQUENCY_SELECT = 1;
	localparam int MODE_GUARD = 2;
	localparam int PLL_STBY = 0;
	localparam int CTRL_TRIG = 8;
	localparam int MS_AUTH = 0;
	localparam int MS_UNLOCK = 1;
	localparam int MS_PING_OK = 2;
	localparam int MS_CTRL_ERR = 3;
	localparam int MS_RX_DONE = 4;
	localparam int MS_RX_OVF = 5;
	localparam int MS_REMOTE_REJ = 6;
	localparam int CS_RDY = 0;
	localparam int CS_BUSY = 1;
	localparam int CS_DVALID = 2;
	localparam int CS_TIMEOUT = 3;
	localparam int CS_REJECT = 4;
	localparam int CS_DONE = 5;
	localparam int CS_NACK = 6;

	// Channel commands and the stream channel.
	localparam logic [2:0] CMD_READ32 = 3'h1;
	localparam logic [2:0] CMD_WRITE32 = 3'h2;
	localparam logic [2:0] CMD_STREAM_TX = 3'h3;
	localparam logic [2:0] CMD_STREAM_RX = 3'h4;
	localparam logic [2:0] WINDOW_LIMIT = 3'h4;
	localparam logic [1:0] STREAM_CH = 2'h2;

	// Frame codes carried on the link.
	localparam logic [3:0] F_PING = 4'h1;
	localparam logic [3:0] F_PING_ACK = 4'h2;
	localparam logic [3:0] F_WR = 4'h3;
	localparam logic [3:0] F_WR_ACK = 4'h4;
	localparam logic [3:0] F_RD = 4'h5;
	localparam logic [3:0] F_RD_RESP = 4'h6;
	localparam logic [3:0] F_ST = 4'h7;
	localparam logic [3:0] F_ST_ACK = 4'h8;
	localparam logic [3:0] F_NACK = 4'h9;
	localparam logic [6:0] FRAME_BITS = 7'h46;
	localparam logic [6:0] FRAME_LAST = 7'h01;

	localparam logic [7:0] PING_PAYLOAD = 8'h00;
	localparam logic [31:0] AUTH_KEY_ADDR = 32'hFFFF_FF00;
	localparam logic [31:0] PAY128_BYTES = 32'h0000_0010;
	localparam logic [31:0] PAY256_BYTES = 32'h0000_0020;
	localparam logic [31:0] TIMEOUT_RST = 32'h0000_0400;
	localparam logic [31:0] ONE32 = 32'h0000_0001;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Reference clock output divider.
	localparam int CLK_HZ = 40000000;
	localparam int REF10_HZ = 10000000;
	localparam int REF20_HZ = 20000000;
	localparam logic [1:0] HALF10 = 2'(CLK_HZ / (2 * REF10_HZ) - 1);
	localparam logic [1:0] HALF20 = 2'(CLK_HZ / (2 * REF20_HZ) - 1);

	typedef enum logic [1:0] {SLCE_CH_IDLE, SLCE_CH_QUEUED, SLCE_CH_WAIT} slce_ch_phase_t;

	typedef struct packed {
		slce_ch_phase_t phase;
		logic [2:0] cmd;
		logic [31:0] addr;
		logic [31:0] data;
		logic [31:0] timer;
		logic [31:0] left;
		logic [31:0] offset;
		logic [6:0] st;
	} slce_ch_t;

	typedef struct packed {
		logic awready, wready, aw_got, w_got, bvalid, arready, rvalid;
		logic [1:0] bresp, rresp;
		logic [7:0] aw_addr;
		logic [31:0] w_data, rdata;
		logic [3:0] w_strb;
		logic [2:0] mode;
		logic pll_stby, ctrl_trig, unlocked, srx_armed;
		logic [7:0] ctrl_payload;
		logic [6:0] main_st;
		logic [31:0] key, timeout, stx_bc, srx_ds, srx_bc, srx_addr, stx_src, srx_cnt;
		logic stx_size, srx_size;
		logic [NUM_CH-1:0][31:0] mbox;
		slce_ch_t [NUM_CH-1:0] ch;
		logic lclk_s1, lclk_s2, lclk_s3, rxd_s1, rxd_s2;
		logic tx_busy, txd, rx_busy;
		logic [69:0] tx_sh, rx_sh;
		logic [6:0] tx_cnt, rx_cnt;
		logic resp_pend;
		logic [3:0] resp_code;
		logic [1:0] resp_chan;
		logic [31:0] resp_arg0, resp_arg1;
		logic [1:0] ref_div;
		logic reference_clock_pin, reference_clock_pin_oe;
	} slce_state_t;

endpackage
